// *** rtl/mtf_map.svh ***
// register offsets, field positions, reset values and frame timing of the tx flow-control block
// assumes a 12-bit register address and one byte per clock on the phy side
`ifndef MTF_MAP_SVH
`define MTF_MAP_SVH

`define MTF_ADDR_W 12
`define MTF_OFS_MAC_TRANSMIT_CONTROL 12'h108
`define MTF_OFS_FLOW 12'h10c
`define MTF_OFS_SEED 12'h110
`define MTF_OFS_ADDR_HI 12'h118
`define MTF_OFS_ADDR_LO 12'h11c
`define MTF_OFS_WMARK 12'h1c0
`define MTF_OFS_INT_STS 12'h1c4
`define MTF_OFS_INT_CLR 12'h1c8
`define MTF_OFS_INT_EN 12'h1cc

`define MTF_BIT_TX_ON 0
`define MTF_BIT_TX_DIS 1
`define MTF_BIT_BAD_CRC 2
`define MTF_BIT_FWD 28
`define MTF_BIT_HONOR 29
`define MTF_BIT_AUTO 30
`define MTF_BIT_FORCE 31

`define MTF_SEED_RST 16'h9876
`define MTF_PVAL_RST 16'h0000
`define MTF_ADDR_HI_RST 16'hffff
`define MTF_ADDR_LO_RST 32'hffffffff

`define MTF_EV_TX_DIS 0
`define MTF_EV_PAUSE_TX 1
`define MTF_EV_PAUSE_RX 2

`define MTF_FILL_SHIFT 9
`define MTF_SLOT_BYTES 22'h000040
`define MTF_PRE_LAST 16'h0006
`define MTF_MIN_LAST 16'h003b
`define MTF_FCS_LAST 16'h0003
`define MTF_IFG_LAST 16'h000b
`define MTF_PREAMBLE 8'h55
`define MTF_SFD 8'hd5
`define MTF_CRC_POLY 32'hedb88320

`endif

// *** rtl/mtf_pkg.sv ***
// types of the tx flow-control block: fsm states and the registered state record
// assumes mtf_map.svh for widths
package mtf_pkg;

    typedef enum logic [2:0] {S_IDLE, S_PRE, S_DATA, S_PAD, S_FCS, S_IFG} mtf_fsm_t;

    typedef struct packed {
        mtf_fsm_t fsm;
        logic [15:0] cnt;
        logic [31:0] crc;
        logic src_pause;
        logic fr_force;
        logic [15:0] fr_val;
        logic [7:0] txd;
        logic transmitter_on_bit;
        logic tx_on;
        logic bad_crc;
        logic tx_dis;
        logic dis_pend;
        logic force_send;
        logic auto_en;
        logic honor;
        logic fwd;
        logic [15:0] pval;
        logic [15:0] seed;
        logic [15:0] lfsr;
        logic [15:0] addr_hi;
        logic [31:0] addr_lo;
        logic [7:0] wm_on;
        logic [7:0] wm_off;
        logic xoff;
        logic auto_req;
        logic auto_zero;
        logic [21:0] hold;
        logic [2:0] sts;
        logic [2:0] ien;
        logic [31:0] rdata;
    } mtf_state_t;

endpackage : mtf_pkg

// *** rtl/mtf_pause_frame.sv ***
// byte lookup of a generated mac control pause frame (60 bytes before fcs)
// assumes the caller walks idx from 0 to 59 and registers the byte
`timescale 1ns/1ps
module mtf_pause_frame (
    input wire logic [5:0] idx,
    input wire logic [47:0] src_addr,
    input wire logic [15:0] pause_value,
    output logic [7:0] byte_out
);
    ////////////////////////////////////////////////////////////////////////
    // reserved multicast da, station sa, control type, pause opcode, value, pad
    always_comb begin
        case (idx)
            6'h00: byte_out = 8'h01;
            6'h01: byte_out = 8'h80;
            6'h02: byte_out = 8'hc2;
            6'h03: byte_out = 8'h00;
            6'h04: byte_out = 8'h00;
            6'h05: byte_out = 8'h01;
            6'h06: byte_out = src_addr[7:0];
            6'h07: byte_out = src_addr[15:8];
            6'h08: byte_out = src_addr[23:16];
            6'h09: byte_out = src_addr[31:24];
            6'h0a: byte_out = src_addr[39:32];
            6'h0b: byte_out = src_addr[47:40];
            6'h0c: byte_out = 8'h88;
            6'h0d: byte_out = 8'h08;
            6'h0e: byte_out = 8'h00;
            6'h0f: byte_out = 8'h01;
            6'h10: byte_out = pause_value[15:8];
            6'h11: byte_out = pause_value[7:0];
            default: byte_out = 8'h00;
        endcase
    end
endmodule : mtf_pause_frame

// *** rtl/mtf_tx_flow.sv ***
// transmit control of an ethernet mac: enable/disable, bad fcs, pause flow control, seed
// assumes one byte per clock at the phy, a source that streams a frame without gaps,
// and a receive parser that pulses rx_pause_seen on each valid pause frame
// Behaviour
// - bad-crc bit corrupts fcs of every frame
// - transmit only while enable bit set
// - frame in flight completes after enable clears
// - disabled flag set on completion, write clears
// - honored pause holds transmit quanta times slot
// - honoring off: pauses ignored, no decode
// - force bit sends one pause, self-clears
// - auto pause when fill/512 reaches on level
// - zero pause when fill/512 drops to off
// - flow control only in full duplex
// - forward bit keeps or sinks received pauses
// - pause value field fills forced and auto-on frames
// - seed field loads back-off lfsr
// - pause source address is station address
`timescale 1ns/1ps
`include "mtf_map.svh"
module mtf_tx_flow #(
    parameter int FILL_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    input wire logic in_last,
    output logic in_ready,
    output logic [7:0] txd,
    output logic tx_en,
    input wire logic full_duplex,
    input wire logic rx_pause_seen,
    input wire logic [15:0] rx_pause_quanta,
    output logic rx_pause_discard,
    input wire logic [FILL_W-1:0] rx_fifo_fill_level,
    output logic [15:0] backoff_random,
    output logic irq
);
    if (FILL_W <= `MTF_FILL_SHIFT || FILL_W > 24) begin : g_bad_fill
        $error("FILL_W must be 10 to 24");
    end

    mtf_pkg::mtf_state_t st;
    mtf_pkg::mtf_state_t next_st;
    logic [7:0] pause_byte;
    logic [FILL_W-1:0] lvl;

    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MTF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_upd

    mtf_pause_frame u_pause (
        .idx(st.cnt[5:0]),
        .src_addr({st.addr_hi, st.addr_lo}),
        .pause_value(st.fr_val),
        .byte_out(pause_byte)
    );

    assign lvl = rx_fifo_fill_level >> `MTF_FILL_SHIFT;
    assign in_ready = (st.fsm == mtf_pkg::S_DATA) && !st.src_pause;
    // honoring off means no decode, so nothing is sunk
    assign rx_pause_discard = rx_pause_seen && st.honor && full_duplex && !st.fwd;
    assign txd = st.txd;
    assign tx_en = st.transmitter_on_bit;
    assign reg_rdata = st.rdata;
    assign backoff_random = st.lfsr;
    assign irq = |(st.sts & st.ien);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] fcs;
        logic wr_force;
        next_st = st;
        fcs = st.bad_crc ? st.crc : ~st.crc;
        wr_force = reg_wr && reg_addr == `MTF_OFS_FLOW && reg_wdata[`MTF_BIT_FORCE];
        next_st.transmitter_on_bit = 1'b0;
        next_st.txd = 8'h00;
        next_st.rdata = 32'h00000000;
        next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
        if (st.hold != 22'h000000) begin
            next_st.hold = st.hold - 22'h000001;
        end
        if (!st.honor) begin
            next_st.hold = 22'h000000;
        end

        // register writes; hardware sets below win over these clears
        if (reg_wr) begin
            case (reg_addr)
                `MTF_OFS_MAC_TRANSMIT_CONTROL: begin
                    next_st.tx_on = reg_wdata[`MTF_BIT_TX_ON];
                    next_st.bad_crc = reg_wdata[`MTF_BIT_BAD_CRC];
                    next_st.dis_pend = !reg_wdata[`MTF_BIT_TX_ON] && (st.tx_on || st.dis_pend);
                    if (reg_wdata[`MTF_BIT_TX_DIS]) begin
                        next_st.tx_dis = 1'b0;
                    end
                end
                `MTF_OFS_FLOW: begin
                    next_st.auto_en = reg_wdata[`MTF_BIT_AUTO];
                    next_st.honor = reg_wdata[`MTF_BIT_HONOR];
                    next_st.fwd = reg_wdata[`MTF_BIT_FWD];
                    next_st.pval = reg_wdata[15:0];
                end
                `MTF_OFS_SEED: begin
                    next_st.seed = reg_wdata[15:0];
                    next_st.lfsr = reg_wdata[15:0];
                end
                `MTF_OFS_ADDR_HI: next_st.addr_hi = reg_wdata[15:0];
                `MTF_OFS_ADDR_LO: next_st.addr_lo = reg_wdata;
                `MTF_OFS_WMARK: begin
                    next_st.wm_on = reg_wdata[7:0];
                    next_st.wm_off = reg_wdata[15:8];
                end
                `MTF_OFS_INT_CLR: next_st.sts = st.sts & ~reg_wdata[2:0];
                `MTF_OFS_INT_EN: next_st.ien = reg_wdata[2:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `MTF_OFS_MAC_TRANSMIT_CONTROL: next_st.rdata = {29'h0, st.bad_crc, st.tx_dis, st.tx_on};
                `MTF_OFS_FLOW: next_st.rdata = {st.force_send, st.auto_en, st.honor, st.fwd,
                                                12'h000, st.pval};
                `MTF_OFS_SEED: next_st.rdata = {16'h0000, st.seed};
                `MTF_OFS_ADDR_HI: next_st.rdata = {16'h0000, st.addr_hi};
                `MTF_OFS_ADDR_LO: next_st.rdata = st.addr_lo;
                `MTF_OFS_WMARK: next_st.rdata = {16'h0000, st.wm_off, st.wm_on};
                `MTF_OFS_INT_STS: next_st.rdata = {29'h0, st.sts};
                `MTF_OFS_INT_EN: next_st.rdata = {29'h0, st.ien};
                default: next_st.rdata = 32'h00000000;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        case (st.fsm)
            mtf_pkg::S_IDLE: begin
                next_st.cnt = 16'h0000;
                if (!st.tx_on) begin
                    if (st.dis_pend) begin
                        next_st.tx_dis = 1'b1;
                        next_st.dis_pend = 1'b0;
                        next_st.sts[`MTF_EV_TX_DIS] = 1'b1;
                    end
                end else if (full_duplex && (st.force_send || st.auto_req)) begin
                    next_st.src_pause = 1'b1;
                    next_st.fr_force = st.force_send;
                    // an auto release frame carries zero, everything else the field
                    next_st.fr_val = (!st.force_send && st.auto_zero) ? 16'h0000 : st.pval;
                    next_st.fsm = mtf_pkg::S_PRE;
                    next_st.transmitter_on_bit = 1'b1;
                    next_st.txd = `MTF_PREAMBLE;
                end else if (in_valid && (st.hold == 22'h000000 || !full_duplex)) begin
                    next_st.src_pause = 1'b0;
                    next_st.fsm = mtf_pkg::S_PRE;
                    next_st.transmitter_on_bit = 1'b1;
                    next_st.txd = `MTF_PREAMBLE;
                end
            end
            mtf_pkg::S_PRE: begin
                next_st.transmitter_on_bit = 1'b1;
                next_st.cnt = st.cnt + 16'h0001;
                next_st.txd = `MTF_PREAMBLE;
                if (st.cnt == `MTF_PRE_LAST) begin
                    next_st.txd = `MTF_SFD;
                    next_st.fsm = mtf_pkg::S_DATA;
                    next_st.cnt = 16'h0000;
                    next_st.crc = 32'hffffffff;
                end
            end
            mtf_pkg::S_DATA: begin
                // a starving source leaves tx_en low mid-frame: an underrun the link sees
                if (st.src_pause || in_valid) begin
                    next_st.transmitter_on_bit = 1'b1;
                    next_st.txd = st.src_pause ? pause_byte : in_data;
                    next_st.crc = crc_upd(st.crc, next_st.txd);
                    next_st.cnt = st.cnt + 16'h0001;
                    if (st.src_pause ? (st.cnt == `MTF_MIN_LAST) : in_last) begin
                        next_st.fsm = (st.cnt < `MTF_MIN_LAST) ? mtf_pkg::S_PAD : mtf_pkg::S_FCS;
                        if (st.cnt >= `MTF_MIN_LAST) begin
                            next_st.cnt = 16'h0000;
                        end
                    end
                end
            end
            mtf_pkg::S_PAD: begin
                next_st.transmitter_on_bit = 1'b1;
                next_st.crc = crc_upd(st.crc, 8'h00);
                next_st.cnt = st.cnt + 16'h0001;
                if (st.cnt == `MTF_MIN_LAST) begin
                    next_st.fsm = mtf_pkg::S_FCS;
                    next_st.cnt = 16'h0000;
                end
            end
            mtf_pkg::S_FCS: begin
                // the frame ends here even if enable was cleared meanwhile
                next_st.transmitter_on_bit = 1'b1;
                next_st.txd = fcs[8*st.cnt[1:0] +: 8];
                next_st.cnt = st.cnt + 16'h0001;
                if (st.cnt == `MTF_FCS_LAST) begin
                    next_st.fsm = mtf_pkg::S_IFG;
                    next_st.cnt = 16'h0000;
                    if (st.src_pause) begin
                        next_st.sts[`MTF_EV_PAUSE_TX] = 1'b1;
                        if (st.fr_force) begin
                            next_st.force_send = 1'b0;
                        end else begin
                            next_st.auto_req = 1'b0;
                        end
                    end
                end
            end
            mtf_pkg::S_IFG: begin
                next_st.cnt = st.cnt + 16'h0001;
                if (st.cnt == `MTF_IFG_LAST) begin
                    next_st.fsm = mtf_pkg::S_IDLE;
                end
            end
            default: next_st.fsm = mtf_pkg::S_IDLE;
        endcase

        ////////////////////////////////////////////////////////////////////
        if (rx_pause_seen && st.honor && full_duplex) begin
            next_st.hold = rx_pause_quanta * `MTF_SLOT_BYTES;
            next_st.sts[`MTF_EV_PAUSE_RX] = 1'b1;
        end
        if (!st.auto_en) begin
            next_st.xoff = 1'b0;
            next_st.auto_req = 1'b0;
        end else if (full_duplex) begin
            if (!st.xoff && lvl >= FILL_W'(st.wm_on)) begin
                next_st.xoff = 1'b1;
                next_st.auto_req = 1'b1;
                next_st.auto_zero = 1'b0;
            end else if (st.xoff && lvl <= FILL_W'(st.wm_off)) begin
                next_st.xoff = 1'b0;
                next_st.auto_req = 1'b1;
                next_st.auto_zero = 1'b1;
            end
        end
        if (wr_force) begin
            next_st.force_send = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.fsm <= mtf_pkg::S_IDLE;
            st.pval <= `MTF_PVAL_RST;
            st.seed <= `MTF_SEED_RST;
            st.lfsr <= `MTF_SEED_RST;
            st.addr_hi <= `MTF_ADDR_HI_RST;
            st.addr_lo <= `MTF_ADDR_LO_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_idle_when_off: assert property ((st.fsm == mtf_pkg::S_IDLE && !st.tx_on) |=> !st.transmitter_on_bit)
        else $error("frame started while transmitter off");
    chk_frame_runs_out: assert property ((!st.tx_on && st.fsm == mtf_pkg::S_PAD) |=>
        st.fsm inside {mtf_pkg::S_PAD, mtf_pkg::S_FCS})
        else $error("frame cut short after disable");
    chk_dis_flag_set: assert property ($rose(st.tx_dis) |->
        !$past(st.tx_on) && $past(st.fsm) == mtf_pkg::S_IDLE && $past(st.dis_pend))
        else $error("disabled flag set outside completion");
    chk_force_clear: assert property ($fell(st.force_send) |->
        $past(st.fsm) == mtf_pkg::S_FCS && $past(st.src_pause) && $past(st.fr_force))
        else $error("force bit cleared without pause frame");
    chk_pause_load: assert property ((rx_pause_seen && st.honor && full_duplex) |=>
        st.hold == {$past(rx_pause_quanta), 6'h00})
        else $error("pause hold not loaded with quanta times slot");
    chk_no_honor: assert property (!st.honor |=> st.hold == 22'h000000)
        else $error("pause hold active with honoring off");
    chk_auto_on: assert property ((st.auto_en && full_duplex && !st.xoff &&
        lvl >= FILL_W'(st.wm_on)) |=> st.xoff && st.auto_req && !st.auto_zero)
        else $error("high watermark did not request pause");
    chk_auto_off: assert property ((st.auto_en && full_duplex && st.xoff &&
        lvl <= FILL_W'(st.wm_off)) |=> !st.xoff && st.auto_req && st.auto_zero)
        else $error("low watermark did not request zero pause");
    chk_half_duplex: assert property ((!full_duplex && st.fsm == mtf_pkg::S_IDLE) |=>
        !(st.fsm == mtf_pkg::S_PRE && st.src_pause))
        else $error("pause frame started in half duplex");
    chk_seed_load: assert property ((reg_wr && reg_addr == `MTF_OFS_SEED) |=>
        st.lfsr == $past(reg_wdata[15:0]) ##1 st.lfsr != $past(st.lfsr))
        else $error("seed write did not load the lfsr");
endmodule : mtf_tx_flow

// *** verification/mtf_link_peer.sv ***
// link partner model: takes frames off the phy byte stream and sends received pauses
// assumes one byte per clock while tx_en is high, led by 7 preamble bytes and an sfd
`timescale 1ns/1ps
module mtf_link_peer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] txd,
    input wire logic tx_en,
    input wire logic rx_pause_discard,
    output logic rx_pause_seen,
    output logic [15:0] rx_pause_quanta,
    output logic fr_done,
    output logic [15:0] fr_len,
    output logic [1:0] fr_kind,
    output logic [7:0] fr_b0,
    output logic [7:0] fr_sa0,
    output logic [31:0] fr_sig
);
    logic [7:0] buf_b [0:2047];
    int cnt = 0;
    logic was_en = 1'b0;
    logic [31:0] crc;
    logic [31:0] fcs;
    logic pre_ok;

    initial begin
        rx_pause_seen = 1'b0;
        rx_pause_quanta = 16'h0000;
        fr_done = 1'b0;
    end

    ////////////////////////////////////////
    // kind 1 good fcs, 2 plain crc, 3 bad framing or too short to judge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt = 0;
            was_en = 1'b0;
            fr_done <= 1'b0;
        end else begin
            fr_done <= 1'b0;
            if (tx_en && cnt < 2048) begin
                buf_b[cnt] = txd;
                cnt = cnt + 1;
            end else if (!tx_en && was_en) begin
                pre_ok = (cnt >= 30) && (buf_b[7] == 8'hd5);
                for (int i = 0; i < 7; i++) pre_ok &= (buf_b[i] == 8'h55);
                crc = 32'hffffffff;
                for (int i = 8; i < cnt - 4; i++) begin
                    crc ^= {24'h000000, buf_b[i]};
                    for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
                end
                fcs = {buf_b[cnt-1], buf_b[cnt-2], buf_b[cnt-3], buf_b[cnt-4]};
                fr_kind <= !pre_ok ? 2'h3 : (fcs === ~crc) ? 2'h1 : (fcs === crc) ? 2'h2 : 2'h0;
                fr_len <= 16'(cnt - 12);
                fr_b0 <= buf_b[8];
                fr_sa0 <= buf_b[14];
                fr_sig <= {buf_b[20], buf_b[21], buf_b[24], buf_b[25]};
                fr_done <= 1'b1;
                cnt = 0;
            end
            was_en = tx_en;
        end
    end

    // quanta line shows the inverse of its last value once the pulse is gone
    task automatic send_pause(input logic [15:0] q, output logic sunk);
        rx_pause_seen <= 1'b1;
        rx_pause_quanta <= q;
        @(negedge clk);
        sunk = rx_pause_discard;
        @(posedge clk);
        rx_pause_seen <= 1'b0;
        rx_pause_quanta <= ~q;
    endtask : send_pause
endmodule : mtf_link_peer

// *** verification/tb.sv ***
// self-checking bench of the tx flow-control block: registers, frames, pauses, interrupt
// assumes mtf_link_peer on the phy side and the register map of mtf_map.svh
`timescale 1ns/1ps
`include "mtf_map.svh"
module tb;
    typedef struct packed {
        logic [15:0] len;
        logic [1:0] kind;
        logic [7:0] b0;
        logic [7:0] sa0;
        logic [31:0] sig;
    } mtf_exp_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic in_valid = 1'b0;
    logic in_last = 1'b0;
    logic full_duplex = 1'b1;
    logic [15:0] fill = 16'h0000;
    logic [31:0] reg_rdata, fr_sig;
    logic [7:0] txd, fr_b0, fr_sa0;
    logic [15:0] rx_pause_quanta, backoff_random, fr_len;
    logic [1:0] fr_kind;
    logic in_ready, tx_en, rx_pause_seen, rx_pause_discard, irq, fr_done;
    mtf_exp_t fr_q[$];
    logic [31:0] rd_q[$];
    logic rd_seen = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    logic [7:0] data_b [0:59];
    int src_idx = 0;

    always #2.5 clk = ~clk;

    mtf_tx_flow #(.FILL_W(16)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_data(in_data), .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready),
        .txd(txd), .tx_en(tx_en), .full_duplex(full_duplex), .rx_pause_seen(rx_pause_seen),
        .rx_pause_quanta(rx_pause_quanta), .rx_pause_discard(rx_pause_discard),
        .rx_fifo_fill_level(fill), .backoff_random(backoff_random), .irq(irq));
    mtf_link_peer u_peer (.clk(clk), .rst_n(rst_n), .txd(txd), .tx_en(tx_en),
        .rx_pause_discard(rx_pause_discard), .rx_pause_seen(rx_pause_seen),
        .rx_pause_quanta(rx_pause_quanta), .fr_done(fr_done), .fr_len(fr_len),
        .fr_kind(fr_kind), .fr_b0(fr_b0), .fr_sa0(fr_sa0), .fr_sig(fr_sig));

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_frame(input mtf_exp_t got, input mtf_exp_t exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: frame %h expected %h", $time, got, exp);
        end
    endtask : chk_frame

    task automatic time_out();
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        give_verdict();
    endtask : time_out

    // read data stand only in the cycle after the strobe, so look exactly there
    always @(posedge clk) begin
        if (rd_seen) chk_word(reg_rdata, rd_q.pop_front());
        rd_seen <= reg_rd;
        if (fr_done) begin
            if (fr_q.size() == 0) chk_frame({fr_len, fr_kind, fr_b0, fr_sa0, fr_sig}, '0);
            else chk_frame({fr_len, fr_kind, fr_b0, fr_sa0, fr_sig}, fr_q.pop_front());
        end
        if (in_valid && in_ready) begin
            src_idx = src_idx + 1;
            in_data <= data_b[src_idx % 60];
            in_last <= (src_idx == 59);
            if (in_last) in_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic chk_irq(input logic exp);
        repeat (2) @(negedge clk);
        chk_word({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    task automatic send_frame();
        for (int i = 0; i < 60; i++) data_b[i] = 8'($urandom);
        @(posedge clk);
        src_idx = 0;
        in_data <= data_b[0];
        in_last <= 1'b0;
        in_valid <= 1'b1;
    endtask : send_frame

    function automatic mtf_exp_t exp_data(input logic [1:0] kind);
        return {16'h003c, kind, data_b[0], data_b[6], data_b[12], data_b[13], data_b[16],
            data_b[17]};
    endfunction : exp_data

    // a frame is done once the partner has judged it and the 12 idle cycles have passed
    task automatic wait_frames();
        int n;
        n = 0;
        while ((fr_q.size() != 0 || tx_en !== 1'b0) && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) time_out();
        repeat (12) @(posedge clk);
    endtask : wait_frames

    task automatic wait_start(output int n);
        n = 0;
        while (tx_en !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) time_out();
    endtask : wait_start

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask : test_end

    ////////////////////////////////////////
    initial begin
        logic sunk;
        int n;
        logic [15:0] pval;
        logic [47:0] sa;
        void'($urandom(56));
        repeat (20) @(posedge clk);
        chk_word({16'h0000, backoff_random}, 32'h00009876);
        rst_n <= 1'b1;
        rd(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000000);
        rd(`MTF_OFS_FLOW, 32'h00000000);
        rd(`MTF_OFS_SEED, 32'h00009876);
        rd(`MTF_OFS_ADDR_HI, 32'h0000ffff);
        rd(12'h200, 32'h00000000);
        pval = 16'($urandom);
        wr(`MTF_OFS_SEED, {16'h0000, pval});
        rd(`MTF_OFS_SEED, {16'h0000, pval});
        test_end("registers");
        send_frame();
        repeat (100) @(posedge clk);
        fr_q.push_back(exp_data(2'h1));
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000001);
        wait_frames();
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000005);
        send_frame();
        fr_q.push_back(exp_data(2'h2));
        wait_frames();
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000001);
        test_end("enable and bad fcs");
        wr(`MTF_OFS_INT_EN, 32'h00000001);
        send_frame();
        fr_q.push_back(exp_data(2'h1));
        wait_start(n);
        repeat (20) @(posedge clk);
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000000);
        rd(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000000);
        wait_frames();
        rd(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000002);
        chk_irq(1'b1);
        wr(`MTF_OFS_INT_EN, 32'h00000000);
        chk_irq(1'b0);
        wr(`MTF_OFS_INT_EN, 32'h00000001);
        chk_irq(1'b1);
        wr(`MTF_OFS_INT_CLR, 32'h00000001);
        chk_irq(1'b0);
        rd(`MTF_OFS_INT_STS, 32'h00000000);
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000002);
        rd(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000000);
        wr(`MTF_OFS_MAC_TRANSMIT_CONTROL, 32'h00000001);
        test_end("disable");
        sa = {16'($urandom), 32'($urandom)};
        wr(`MTF_OFS_ADDR_HI, {16'h0000, sa[47:32]});
        wr(`MTF_OFS_ADDR_LO, sa[31:0]);
        pval = 16'($urandom);
        fr_q.push_back({16'h003c, 2'h1, 8'h01, sa[7:0], 16'h8808, pval});
        wr(`MTF_OFS_FLOW, {16'h8000, pval});
        wait_frames();
        rd(`MTF_OFS_FLOW, {16'h0000, pval});
        test_end("forced pause");
        wr(`MTF_OFS_FLOW, {16'h2000, pval});
        u_peer.send_pause(16'h0002, sunk);
        chk_word({31'h0, sunk}, 32'h00000001);
        send_frame();
        fr_q.push_back(exp_data(2'h1));
        wait_start(n);
        chk_word(32'(n >= 120 && n < 150), 32'h00000001);
        wait_frames();
        wr(`MTF_OFS_FLOW, {16'h3000, pval});
        u_peer.send_pause(16'h0000, sunk);
        chk_word({31'h0, sunk}, 32'h00000000);
        wr(`MTF_OFS_FLOW, {16'h0000, pval});
        for (int d = 0; d < 2; d++) begin
            if (d == 1) begin
                full_duplex <= 1'b0;
                wr(`MTF_OFS_FLOW, {16'h2000, pval});
            end
            u_peer.send_pause(16'h00ff, sunk);
            chk_word({31'h0, sunk}, 32'h00000000);
            send_frame();
            fr_q.push_back(exp_data(2'h1));
            wait_start(n);
            chk_word(32'(n < 30), 32'h00000001);
            wait_frames();
        end
        full_duplex <= 1'b1;
        test_end("received pauses");
        wr(`MTF_OFS_WMARK, 32'h00000104);
        wr(`MTF_OFS_FLOW, {16'h4000, pval});
        fill <= 16'h07ff;
        repeat (100) @(posedge clk);
        fr_q.push_back({16'h003c, 2'h1, 8'h01, sa[7:0], 16'h8808, pval});
        fill <= 16'h0800;
        wait_frames();
        fr_q.push_back({16'h003c, 2'h1, 8'h01, sa[7:0], 16'h8808, 16'h0000});
        fill <= 16'h0200;
        wait_frames();
        test_end("watermarks");
        give_verdict();
    end
endmodule : tb
